// ---- pkg/jump_inc_consts.svh ----
// Constants for the absolute jump and file increment executor.
`ifndef JUMP_INC_CONSTS_SVH
`define JUMP_INC_CONSTS_SVH
`define JMP_FIRST_OP 8'hef
`define JMP_SECOND_OP 4'hf
`define INC_OP 6'h0a
`define INDEXED_LIMIT 8'h5f
`define ACCESS_HIGH_START 8'h60
`define ACCESS_HIGH_BANK 4'hf
`define PROG_CNT_RESET 21'h000000
`define PROG_CNT_STEP 21'h000002
`define WORD_ALIGN 1'h0
`define INC_STEP_WIDE 9'h001
`define NIBBLE_STEP 5'h01
`define OVERFLOW_OPERAND 8'h7f
`define ZERO_NIBBLE 4'h0
`define OPCODE_MSB 15
`define JMP_FIRST_LSB 8
`define JMP_SECOND_LSB 12
`define INC_OP_LSB 10
`define DEST_BIT 9
`define ACCESS_BIT 8
`define LIT_HIGH_MSB 11
`define FILE_MSB 7
`define FILE_LSB 0
`define NIBBLE_MSB 3
`define CARRY_BIT 8
`define NIBBLE_CARRY_BIT 4
`define SIGN_BIT 7
`define BYTE_RESET 8'h00
`define BANK_RESET 4'h0
`endif

// ---- pkg/jump_inc_pkg.sv ----
// Types shared by the jump and increment executor.
package jump_inc_pkg;
  typedef enum logic [1:0] {
    ST_DECODE = 2'b00,
    ST_JUMP_SECOND = 2'b01,
    ST_JUMP_NOP = 2'b10
  } exec_state_type;
  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic negative;
    logic overflow_flag;
    logic zero;
  } status_flags_type;
  typedef struct packed {
    logic wr_en;
    logic [11:0] addr;
    logic [7:0] data;
  } file_write_type;
endpackage : jump_inc_pkg

// ---- src/jump_and_increment_exec.sv ----
// Executor for the two-word absolute jump and the file register increment.
//
// Functional notes
// - Jump is two words, EFh then Fh prefix.
// - Jump literal loads program counter bits 20..1.
// - Jump takes three cycles, third is no-op.
// - Increment reads file, adds one, writes destination.
// - Destination bit 0 writes working register only.
// - Destination bit 1 writes back to file.
// - Bank bit 0 addresses the access bank.
// - Extended set, bank 0, f<=5Fh is indexed.
`timescale 1ns/1ps
`include "jump_inc_consts.svh"

module jump_and_increment_exec
  import jump_inc_pkg::*;
(
  // Clock and reset.
  input wire logic CLK,
  input wire logic ARST_N,
  // Instruction cycle and fetched word.
  input wire logic INSTR_CYCLE_EN,
  input wire logic [15:0] INSTR_WORD,
  // Core state inputs.
  input wire logic EXTENDED_SET_EN,
  input wire logic [3:0] BANK_SELECT_REGISTER,
  input wire logic [11:0] INDEX_BASE,
  input wire logic [7:0] FILE_READ_DATA,
  // File address presented for the read.
  output logic [11:0] FILE_READ_ADDR,
  // Results.
  output logic [20:0] PROGRAM_COUNTER,
  output logic [7:0] WORKING_REG,
  output file_write_type FILE_WRITE,
  output status_flags_type STATUS_FLAGS,
  output logic JUMP_BUSY
);

  // ------------------------------------------------------------------
  // Registers and decode signals.
  // ------------------------------------------------------------------
  exec_state_type state_reg, state_next;
  logic busy_reg, busy_next;
  logic [7:0] low_lit_reg, low_lit_next;
  logic [20:0] prog_cnt_reg, prog_cnt_next;
  logic [7:0] w_reg, w_next;
  file_write_type fw_reg, fw_next;
  status_flags_type flags_reg, flags_next;
  logic [11:0] raddr_reg, raddr_next;
  logic [7:0] file_field;
  logic dest_to_file;
  logic bank_mode;
  logic is_jump_first;
  logic is_jump_second;
  logic is_inc;
  logic do_inc;
  logic [11:0] inc_addr;
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] result;

  // ------------------------------------------------------------------
  // Instruction field decode.
  // ------------------------------------------------------------------
  assign file_field = INSTR_WORD[`FILE_MSB:`FILE_LSB];
  assign dest_to_file = INSTR_WORD[`DEST_BIT];
  assign bank_mode = INSTR_WORD[`ACCESS_BIT];
  assign is_jump_first = (INSTR_WORD[`OPCODE_MSB:`JMP_FIRST_LSB] == `JMP_FIRST_OP);
  assign is_jump_second = (INSTR_WORD[`OPCODE_MSB:`JMP_SECOND_LSB] == `JMP_SECOND_OP);
  assign is_inc = (INSTR_WORD[`OPCODE_MSB:`INC_OP_LSB] == `INC_OP);
  // An increment only runs on an enabled edge while no jump is in flight.
  assign do_inc = INSTR_CYCLE_EN && (state_reg == ST_DECODE) && is_inc;

  // ------------------------------------------------------------------
  // Address formation for the increment.
  // ------------------------------------------------------------------
  always_comb begin
    if (bank_mode) begin
      inc_addr = {BANK_SELECT_REGISTER, file_field};
    end else if (EXTENDED_SET_EN && (file_field <= `INDEXED_LIMIT)) begin
      inc_addr = INDEX_BASE + {`ZERO_NIBBLE, file_field};
    end else if (file_field >= `ACCESS_HIGH_START) begin
      inc_addr = {`ACCESS_HIGH_BANK, file_field};
    end else begin
      inc_addr = {`ZERO_NIBBLE, file_field};
    end
  end

  // ------------------------------------------------------------------
  // Increment arithmetic.
  // ------------------------------------------------------------------
  assign sum = {1'h0, FILE_READ_DATA} + `INC_STEP_WIDE;
  assign low_sum = {1'h0, FILE_READ_DATA[`NIBBLE_MSB:`FILE_LSB]} + `NIBBLE_STEP;
  assign result = sum[`FILE_MSB:`FILE_LSB];

  // ------------------------------------------------------------------
  // Jump sequencer.
  // ------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    low_lit_next = low_lit_reg;
    if (INSTR_CYCLE_EN) begin
      case (state_reg)
        ST_DECODE: begin
          if (is_jump_first) begin
            low_lit_next = file_field;
            state_next = ST_JUMP_SECOND;
          end
        end
        ST_JUMP_SECOND: begin
          if (is_jump_second) begin
            state_next = ST_JUMP_NOP;
          end else begin
            state_next = ST_DECODE;
          end
        end
        ST_JUMP_NOP: begin
          state_next = ST_DECODE;
        end
        default: begin
          state_next = ST_DECODE;
        end
      endcase
    end
    busy_next = (state_next != ST_DECODE);
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= ST_DECODE;
      busy_reg <= 1'h0;
      low_lit_reg <= `BYTE_RESET;
    end else begin
      state_reg <= state_next;
      busy_reg <= busy_next;
      low_lit_reg <= low_lit_next;
    end
  end

  // ------------------------------------------------------------------
  // Program counter.
  // ------------------------------------------------------------------
  always_comb begin
    prog_cnt_next = prog_cnt_reg;
    if (INSTR_CYCLE_EN) begin
      case (state_reg)
        ST_DECODE: begin
          if (!is_jump_first) begin
            prog_cnt_next = prog_cnt_reg + `PROG_CNT_STEP;
          end
        end
        ST_JUMP_SECOND: begin
          if (is_jump_second) begin
            prog_cnt_next = {INSTR_WORD[`LIT_HIGH_MSB:`FILE_LSB], low_lit_reg, `WORD_ALIGN};
          end else begin
            prog_cnt_next = prog_cnt_reg + `PROG_CNT_STEP;
          end
        end
        ST_JUMP_NOP: begin
          prog_cnt_next = prog_cnt_reg;
        end
        default: begin
          prog_cnt_next = prog_cnt_reg;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prog_cnt_reg <= `PROG_CNT_RESET;
    end else begin
      prog_cnt_reg <= prog_cnt_next;
    end
  end

  // ------------------------------------------------------------------
  // Working register.
  // ------------------------------------------------------------------
  always_comb begin
    w_next = w_reg;
    if (do_inc && !dest_to_file) begin
      w_next = result;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      w_reg <= `BYTE_RESET;
    end else begin
      w_reg <= w_next;
    end
  end

  // ------------------------------------------------------------------
  // File register write-back.
  // ------------------------------------------------------------------
  always_comb begin
    fw_next = fw_reg;
    fw_next.wr_en = 1'h0;
    if (do_inc && dest_to_file) begin
      fw_next.wr_en = 1'h1;
      fw_next.addr = inc_addr;
      fw_next.data = result;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fw_reg <= '0;
    end else begin
      fw_reg <= fw_next;
    end
  end

  // ------------------------------------------------------------------
  // Status flags.
  // ------------------------------------------------------------------
  always_comb begin
    flags_next = flags_reg;
    if (do_inc) begin
      flags_next.carry = sum[`CARRY_BIT];
      flags_next.digit_carry_flag = low_sum[`NIBBLE_CARRY_BIT];
      flags_next.negative = result[`SIGN_BIT];
      flags_next.overflow_flag = (FILE_READ_DATA == `OVERFLOW_OPERAND);
      flags_next.zero = (result == `BYTE_RESET);
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // ------------------------------------------------------------------
  // Decoded read address, held between instruction cycles.
  // ------------------------------------------------------------------
  always_comb begin
    raddr_next = raddr_reg;
    if (INSTR_CYCLE_EN) begin
      raddr_next = inc_addr;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      raddr_reg <= '0;
    end else begin
      raddr_reg <= raddr_next;
    end
  end

  // ------------------------------------------------------------------
  // Outputs, each straight from its register.
  // ------------------------------------------------------------------
  assign PROGRAM_COUNTER = prog_cnt_reg;
  assign WORKING_REG = w_reg;
  assign FILE_WRITE = fw_reg;
  assign STATUS_FLAGS = flags_reg;
  assign FILE_READ_ADDR = raddr_reg;
  assign JUMP_BUSY = busy_reg;

endmodule : jump_and_increment_exec

// ---- verification/jump_inc_chk.sv ----
// Checker for the jump and increment executor.
`timescale 1ns/1ps
module jump_inc_chk
  import jump_inc_pkg::*;
(
  // Clock, reset and cycle enable.
  input logic CLK,
  input logic ARST_N,
  input logic INSTR_CYCLE_EN,
  // Instruction and core state.
  input logic [15:0] INSTR_WORD,
  input logic EXTENDED_SET_EN,
  input logic [3:0] BANK_SELECT_REGISTER,
  input logic [11:0] INDEX_BASE,
  input logic [7:0] FILE_READ_DATA,
  // Results of the executor.
  input logic [11:0] FILE_READ_ADDR,
  input logic [20:0] PROGRAM_COUNTER,
  input logic [7:0] WORKING_REG,
  input file_write_type FILE_WRITE,
  input status_flags_type STATUS_FLAGS,
  input logic JUMP_BUSY
);
  wire [15:0] w = INSTR_WORD;
  wire inc = INSTR_CYCLE_EN && !JUMP_BUSY && w[15:10] == 6'h0a;
  wire idx = EXTENDED_SET_EN && w[7:0] <= 8'h5f;
  wire [7:0] r = FILE_READ_DATA + 8'h01;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  sequence s_first; INSTR_CYCLE_EN && !JUMP_BUSY && w[15:8] == 8'hef; endsequence
  sequence s_second; s_first ##1 INSTR_CYCLE_EN && w[15:12] == 4'hf; endsequence
  a_jump_busy: assert property (s_first |=> JUMP_BUSY) else $error("busy");
  a_jump_abort: assert property (s_first ##1 INSTR_CYCLE_EN && w[15:12] != 4'hf |=>
    !JUMP_BUSY && PROGRAM_COUNTER == $past(PROGRAM_COUNTER) + 21'h2) else $error("abort");
  a_jump_target: assert property (s_second |=>
    PROGRAM_COUNTER == {$past(w[11:0]), $past(w[7:0], 2), 1'b0}) else $error("target");
  a_jump_nop: assert property (s_second ##1 INSTR_CYCLE_EN |=>
    !JUMP_BUSY && $stable(PROGRAM_COUNTER)) else $error("nop");
  a_inc_file: assert property (inc && w[9] |=> FILE_WRITE.wr_en && FILE_WRITE.data == $past(r))
    else $error("file");
  a_inc_wreg: assert property (inc && !w[9] |=> !FILE_WRITE.wr_en && WORKING_REG == $past(r))
    else $error("wreg");
  a_access_bank: assert property (inc && !w[8] && !idx |=>
    FILE_READ_ADDR == {($past(w[7:0]) >= 8'h60) ? 4'hf : 4'h0, $past(w[7:0])}) else $error("access");
  a_index_mode: assert property (inc && !w[8] && idx |=>
    FILE_READ_ADDR == $past(INDEX_BASE + w[7:0])) else $error("index");
  a_bank_sel: assert property (inc && w[8] |=>
    FILE_READ_ADDR == $past({BANK_SELECT_REGISTER, w[7:0]})) else $error("bank");
  a_inc_flags: assert property (inc |=> STATUS_FLAGS.zero == $past(r == 8'h00) &&
    PROGRAM_COUNTER == $past(PROGRAM_COUNTER) + 21'h2) else $error("flags");
endmodule : jump_inc_chk
bind jump_and_increment_exec jump_inc_chk u_chk (
  .CLK(CLK),
  .ARST_N(ARST_N),
  .INSTR_CYCLE_EN(INSTR_CYCLE_EN),
  .INSTR_WORD(INSTR_WORD),
  .EXTENDED_SET_EN(EXTENDED_SET_EN),
  .BANK_SELECT_REGISTER(BANK_SELECT_REGISTER),
  .INDEX_BASE(INDEX_BASE),
  .FILE_READ_DATA(FILE_READ_DATA),
  .FILE_READ_ADDR(FILE_READ_ADDR),
  .PROGRAM_COUNTER(PROGRAM_COUNTER),
  .WORKING_REG(WORKING_REG),
  .FILE_WRITE(FILE_WRITE),
  .STATUS_FLAGS(STATUS_FLAGS),
  .JUMP_BUSY(JUMP_BUSY)
);

// ---- verification/jump_and_increment_exec_tb.sv ----
// Self-checking bench for the jump and increment executor.
`timescale 1ns/1ps
module jump_and_increment_exec_tb;
  import jump_inc_pkg::*;
  logic clk = 0, rst_n = 0, ext = 0, en = 0, jb;
  logic [15:0] wd = 0;
  logic [3:0] bank = 0;
  logic [11:0] ib = 0, fra;
  logic [7:0] frd = 0, wr, d;
  logic [8:0] fa;
  logic [20:0] prog_cnt, epc = 0;
  logic [19:0] k;
  file_write_type fw;
  status_flags_type sf;
  int fail_count = 0, checks = 0, cyc = 0, seed = 32'hac8a72c1, v, u;
  always #5 clk = ~clk;
  jump_and_increment_exec u_dut (.CLK(clk), .ARST_N(rst_n), .INSTR_CYCLE_EN(en), .INSTR_WORD(wd),
    .EXTENDED_SET_EN(ext), .BANK_SELECT_REGISTER(bank), .INDEX_BASE(ib), .FILE_READ_DATA(frd),
    .FILE_READ_ADDR(fra), .PROGRAM_COUNTER(prog_cnt), .WORKING_REG(wr), .FILE_WRITE(fw), .STATUS_FLAGS(sf),
    .JUMP_BUSY(jb));
  task chk(input string n, input logic [20:0] e, g);
    checks++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", n, e, g);
      fail_count++;
    end
  endtask : chk
  task op(input logic [15:0] x, input logic [7:0] y, input logic e = 1'b1);
    en = e;
    wd = x;
    frd = y;
    @(posedge clk);
    #1;
  endtask : op
  function automatic status_flags_type fl(input logic [7:0] a);
    return {a == 8'hff, a[3:0] == 4'hf, a >= 8'h7f && a != 8'hff, a == 8'h7f, a == 8'hff};
  endfunction : fl
  function automatic logic [11:0] ea(input logic [8:0] a);
    if (a[8]) return {bank, a[7:0]};
    if (ext && a[7:0] <= 8'h5f) return ib + a[7:0];
    return {(a[7:0] >= 8'h60) ? 4'hf : 4'h0, a[7:0]};
  endfunction : ea
  task wrap_up;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cyc++;
    if (cyc > 1000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 rst_n = 1;
    chk("program_counter", 0, prog_cnt);
    for (int i = 0; i < 60; i++) begin
      v = $random(seed);
      u = $random(seed);
      d = i == 0 ? 8'hff : i == 1 ? 8'h7f : u[7:0];
      ext = v[10];
      bank = v[14:11];
      ib = v[26:15];
      fa = {v[8], i == 2 ? 8'h5f : v[7:0]};
      op({6'h0a, v[9], fa}, d);
      epc += 2;
      chk("program_counter", epc, prog_cnt);
      chk("flags", fl(d), sf);
      if (v[9]) begin
        chk("file", {1'b1, d + 8'h01}, {fw.wr_en, fw.data});
        chk("file addr", ea(fa), fw.addr);
      end else begin
        chk("w", {1'b0, d + 8'h01}, {fw.wr_en, wr});
      end
      chk("addr", ea(fa), fra);
    end
    op(16'h0000, 8'h00);
    epc += 2;
    chk("other", epc, prog_cnt);
    chk("other wr_en", 0, fw.wr_en);
    op({6'h0a, 2'h2, 8'h10}, 8'h33, 1'b0);
    chk("idle", epc, prog_cnt);
    chk("idle wr_en", 0, fw.wr_en);
    rst_n = 0;
    #1;
    chk("reset program_counter", 0, prog_cnt);
    chk("reset w", 0, wr);
    @(posedge clk);
    #1 rst_n = 1;
    epc = 0;
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      u = $random(seed);
      k = i == 0 ? 20'hfffff : v[19:0];
      op({8'hef, k[7:0]}, 8'h00);
      chk("busy", 1, jb);
      chk("hold", epc, prog_cnt);
      if (i == 3) begin
        op({4'h7, k[19:8]}, 8'h00);
        epc += 2;
        chk("abort busy", 0, jb);
        chk("abort", epc, prog_cnt);
      end else begin
        op({4'hf, k[19:8]}, 8'h00);
        epc = {k, 1'b0};
        chk("jump", epc, prog_cnt);
        op(u[15:0], 8'h00);
        chk("nop busy", 0, jb);
        chk("nop", epc, prog_cnt);
      end
    end
    wrap_up();
  end
endmodule : jump_and_increment_exec_tb
